// file: hdl/rmc_addr_filter.sv
// per-character receive decision for plain, multidrop and auto address modes
`timescale 1ns/1ps
module rmc_addr_filter
   import rmc_pkg::*;
(
   input  wire rmc_mode_t    mode,
   input  wire logic         rxEnabled,
   input  wire logic [7:0]   matchChar,
   input  wire rmc_char_t    charIn,
   output rmc_verdict_t      verdict
);
   logic isMatch;

   // exact eight-bit compare against the stored character
   assign isMatch = (charIn.data == matchChar);

   // classify one received character
   always_comb begin
      verdict = '0;
      case (mode)
         RMC_MODE_PLAIN: begin
            verdict.accept     = rxEnabled;
            verdict.parityFlag = charIn.parityErr;
         end
         RMC_MODE_MULTIDROP: begin
            if (charIn.ninth) begin
               verdict.accept     = 1'b1;
               verdict.parityFlag = 1'b1;
               verdict.addrEvent  = 1'b1;
            end else begin
               verdict.accept = rxEnabled;
            end
         end
         RMC_MODE_AUTOADDR: begin
            if (charIn.ninth) begin
               verdict.addrEvent = 1'b1;
               if (isMatch) begin
                  verdict.accept     = 1'b1;
                  verdict.parityFlag = 1'b1;
                  verdict.setEnable  = 1'b1;
               end else begin
                  verdict.clrEnable = rxEnabled;
               end
            end else begin
               verdict.accept = rxEnabled;
            end
         end
         default: verdict = '0;
      endcase
      verdict.dropEvent = ~verdict.accept;
   end
endmodule // rmc_addr_filter

// file: hdl/rmc_pkg.sv
// constants and types of the rs-485 multidrop control block
// Notes on behaviour
// - inverted auto direction: rts high while sending, low after last bit
// - control bit selects multidrop mode; ninth bit marks address characters
// - multidrop address character raises an interrupt toward local software
// - disabled receiver drops data characters until an address arrives
// - address character flags parity error, line interrupt, goes to fifo
// - enabled receiver takes data; later address flags parity error again
// - disabled auto detect receiver drops data and non-matching address characters
// - matching address enables receiver, is pushed with flag, interrupts
// - auto detect receiver keeps taking data until a mismatching address arrives or software disables
// - enabled auto receiver: mismatch disables and drops, match stored
// - transmitter direction overrides manual and flow rts sources
// - inversion bit clear: rts low sending; set: rts high sending
package rmc_pkg;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_FEAT   = 8'h04;
   localparam logic [7:0] OFF_MATCH  = 8'h08;
   localparam logic [7:0] OFF_ISTAT  = 8'h0c;
   localparam logic [7:0] OFF_ICLR   = 8'h10;
   localparam logic [7:0] OFF_IEN    = 8'h14;
   localparam logic [7:0] OFF_RXSTAT = 8'h18;
   localparam int CTRL_MULTIDROP_BIT = 0;
   localparam int CTRL_RXDIS_BIT     = 1;
   localparam int CTRL_OWNDIR_BIT    = 4;
   localparam int CTRL_INVERT_BIT    = 5;
   localparam int FEAT_SCD_BIT       = 5;
   localparam int EV_ADDR_BIT        = 0;
   localparam int EV_DROP_BIT        = 1;
   localparam int EV_LINE_BIT        = 2;
   localparam int EV_W               = 3;
   localparam logic [7:0] MATCH_RST  = 8'h00;
   localparam logic [2:0] IEN_RST    = 3'h0;

   typedef enum logic [1:0] {
      RMC_MODE_PLAIN     = 2'b00,
      RMC_MODE_MULTIDROP = 2'b01,
      RMC_MODE_AUTOADDR  = 2'b10
   } rmc_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic       ninth;
      logic       parityErr;
   } rmc_char_t;

   typedef struct packed {
      logic [7:0] data;
      logic       parityErr;
   } rmc_push_t;

   typedef struct packed {
      logic accept;
      logic parityFlag;
      logic setEnable;
      logic clrEnable;
      logic addrEvent;
      logic dropEvent;
   } rmc_verdict_t;

   typedef struct packed {
      logic              multidrop;
      logic              ownsDir;
      logic              invert;
      logic              scdEnable;
      logic [7:0]        matchChar;
      logic [EV_W-1:0]   irqStatus;
      logic [EV_W-1:0]   irqEnable;
      logic              rxEnabled;
      logic              dirActive;
      logic              rtsPin;
      logic              pushValid;
      rmc_push_t         push;
      logic [7:0]        lastAddr;
      logic [31:0]       rdata;
   } rmc_state_t;

   localparam rmc_state_t RMC_STATE_RST = '{
      multidrop: 1'b0, ownsDir: 1'b0, invert: 1'b0, scdEnable: 1'b0,
      matchChar: MATCH_RST, irqStatus: 3'h0, irqEnable: IEN_RST,
      rxEnabled: 1'b1, dirActive: 1'b0, rtsPin: 1'b1, pushValid: 1'b0,
      push: 9'h000, lastAddr: 8'h00, rdata: 32'h0000_0000};
endpackage

// file: hdl/rmc_top.sv
// rs-485 direction control and multidrop receive gating with apb registers
`timescale 1ns/1ps
module rmc_top
   import rmc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [7:0]   paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         txFifoWrite,
   input  wire logic         txLastBitDone,
   input  wire logic         manualRts,
   input  wire logic         flowCtrlOn,
   input  wire logic         flowRts,
   input  wire logic         rxCharValid,
   input  wire rmc_char_t    rxChar,
   output logic              rxPushValid,
   output rmc_push_t         rxPush,
   output logic              rtsN,
   output logic              irq
);
   rmc_state_t   st_reg;
   rmc_state_t   st_next;
   rmc_mode_t    mode;
   rmc_verdict_t verdict;
   logic         wrAcc;
   logic         rdSetup;
   logic         mapped;

   // apb phase decode
   assign wrAcc   = psel & penable & pwrite;
   assign rdSetup = psel & ~penable & ~pwrite;

   // address map check
   always_comb begin
      case (paddr)
         OFF_CTRL, OFF_FEAT, OFF_MATCH, OFF_ISTAT,
         OFF_ICLR, OFF_IEN, OFF_RXSTAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // receive mode from control bits
   always_comb begin
      if (st_reg.multidrop && st_reg.scdEnable) begin
         mode = RMC_MODE_AUTOADDR;
      end else if (st_reg.multidrop) begin
         mode = RMC_MODE_MULTIDROP;
      end else begin
         mode = RMC_MODE_PLAIN;
      end
   end

   rmc_addr_filter u_filter (
      .mode      (mode),
      .rxEnabled (st_reg.rxEnabled),
      .matchChar (st_reg.matchChar),
      .charIn    (rxChar),
      .verdict   (verdict)
   );

   // next state: software writes first, hardware events after so they win
   always_comb begin
      st_next           = st_reg;
      st_next.pushValid = 1'b0;
      if (wrAcc) begin
         case (paddr)
            OFF_CTRL: begin
               st_next.multidrop = pwdata[CTRL_MULTIDROP_BIT];
               st_next.rxEnabled = ~pwdata[CTRL_RXDIS_BIT];
               st_next.ownsDir   = pwdata[CTRL_OWNDIR_BIT];
               st_next.invert    = pwdata[CTRL_INVERT_BIT];
            end
            OFF_FEAT:  st_next.scdEnable = pwdata[FEAT_SCD_BIT];
            OFF_MATCH: st_next.matchChar = pwdata[7:0];
            OFF_ICLR:  st_next.irqStatus = st_reg.irqStatus & ~pwdata[EV_W-1:0];
            OFF_IEN:   st_next.irqEnable = pwdata[EV_W-1:0];
            default:   st_next.irqEnable = st_next.irqEnable;
         endcase
      end
      // received character handling
      if (rxCharValid) begin
         if (verdict.setEnable) begin
            st_next.rxEnabled = 1'b1;
         end
         if (verdict.clrEnable) begin
            st_next.rxEnabled = 1'b0;
         end
         if (verdict.accept) begin
            st_next.pushValid      = 1'b1;
            st_next.push.data      = rxChar.data;
            st_next.push.parityErr = verdict.parityFlag;
         end
         if (verdict.addrEvent) begin
            st_next.lastAddr = rxChar.data;
         end
         if (verdict.addrEvent) begin
            st_next.irqStatus[EV_ADDR_BIT] = 1'b1;
         end
         if (verdict.dropEvent) begin
            st_next.irqStatus[EV_DROP_BIT] = 1'b1;
         end
         if (verdict.accept && verdict.parityFlag) begin
            st_next.irqStatus[EV_LINE_BIT] = 1'b1;
         end
      end
      // transmitter activity window
      if (txFifoWrite) begin
         st_next.dirActive = 1'b1;
      end else if (txLastBitDone) begin
         st_next.dirActive = 1'b0;
      end
      // rts pin source selection
      if (st_reg.ownsDir) begin
         st_next.rtsPin = st_reg.invert ? st_reg.dirActive
                                        : ~st_reg.dirActive;
      end else if (flowCtrlOn) begin
         st_next.rtsPin = flowRts;
      end else begin
         st_next.rtsPin = manualRts;
      end
      // read data captured in the setup cycle
      if (rdSetup) begin
         case (paddr)
            OFF_CTRL: st_next.rdata = {26'h0, st_reg.invert, st_reg.ownsDir,
                                       2'h0, ~st_reg.rxEnabled, st_reg.multidrop};
            OFF_FEAT:   st_next.rdata = {26'h0, st_reg.scdEnable, 5'h00};
            OFF_MATCH:  st_next.rdata = {24'h0, st_reg.matchChar};
            OFF_ISTAT:  st_next.rdata = {29'h0, st_reg.irqStatus};
            OFF_IEN:    st_next.rdata = {29'h0, st_reg.irqEnable};
            OFF_RXSTAT: st_next.rdata = {12'h000, st_reg.dirActive, mode,
                                         st_reg.rxEnabled, st_reg.lastAddr, 8'h00};
            default:    st_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= RMC_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign prdata      = st_reg.rdata;
   assign pready      = psel & penable; // one wait-free access phase
   assign pslverr     = psel & penable & ~mapped;
   assign rxPushValid = st_reg.pushValid;
   assign rxPush      = st_reg.push;
   assign rtsN        = st_reg.rtsPin;
   assign irq         = |(st_reg.irqStatus & st_reg.irqEnable);

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   logic autoMode;
   logic mdMode;
   logic enWrite;
   logic ctrlWrite;
   assign autoMode  = (mode == RMC_MODE_AUTOADDR);
   assign mdMode    = (mode == RMC_MODE_MULTIDROP);
   assign enWrite   = wrAcc && (paddr == OFF_IEN);
   assign ctrlWrite = wrAcc && (paddr == OFF_CTRL);

   property p_rts_inverted_tx;
      (st_reg.ownsDir && st_reg.invert && st_reg.dirActive) |=> rtsN;
   endproperty
   a_rts_inverted_tx: assert property (p_rts_inverted_tx)
      else $error("inverted rts not high while sending");

   property p_rts_assert_on_write;
      (txFifoWrite && st_reg.ownsDir && !st_reg.invert && !ctrlWrite)
         ##1 (st_reg.ownsDir && !st_reg.invert) |=> !rtsN;
   endproperty
   a_rts_assert_on_write: assert property (p_rts_assert_on_write)
      else $error("rts not driven low after transmit write");

   property p_rts_release;
      (st_reg.ownsDir && !st_reg.invert && !st_reg.dirActive) |=> rtsN;
   endproperty
   a_rts_release: assert property (p_rts_release)
      else $error("rts not high while receiving");

   property p_rts_flow_source;
      (!st_reg.ownsDir && flowCtrlOn) |=> (rtsN == $past(flowRts));
   endproperty
   a_rts_flow_source: assert property (p_rts_flow_source)
      else $error("rts does not follow flow control source");

   property p_md_drop_data;
      (mdMode && rxCharValid && !rxChar.ninth && !st_reg.rxEnabled)
         |=> !rxPushValid;
   endproperty
   a_md_drop_data: assert property (p_md_drop_data)
      else $error("data character kept while receiver disabled");

   property p_md_address_flag;
      (mdMode && rxCharValid && rxChar.ninth)
         |=> rxPushValid && rxPush.parityErr && st_reg.irqStatus[EV_LINE_BIT]
             && (rxPush.data == $past(rxChar.data));
   endproperty
   a_md_address_flag: assert property (p_md_address_flag)
      else $error("address character not flagged and stored");

   property p_md_address_irq;
      (mdMode && rxCharValid && rxChar.ninth && st_reg.irqEnable[EV_ADDR_BIT]
         && !enWrite) |=> irq;
   endproperty
   a_md_address_irq: assert property (p_md_address_irq)
      else $error("no interrupt for address character");

   property p_auto_drop;
      (autoMode && rxCharValid && !st_reg.rxEnabled
         && (!rxChar.ninth || rxChar.data != st_reg.matchChar)) |=> !rxPushValid;
   endproperty
   a_auto_drop: assert property (p_auto_drop)
      else $error("character kept without address match");

   property p_auto_match;
      (autoMode && rxCharValid && rxChar.ninth
         && rxChar.data == st_reg.matchChar)
         |=> rxPushValid && rxPush.parityErr && st_reg.rxEnabled;
   endproperty
   a_auto_match: assert property (p_auto_match)
      else $error("matching address did not enable receiver");

   property p_auto_mismatch;
      (autoMode && rxCharValid && rxChar.ninth && st_reg.rxEnabled
         && rxChar.data != st_reg.matchChar)
         |=> !st_reg.rxEnabled && !rxPushValid;
   endproperty
   a_auto_mismatch: assert property (p_auto_mismatch)
      else $error("mismatching address did not disable receiver");

   property p_auto_keep_data;
      (autoMode && rxCharValid && !rxChar.ninth && st_reg.rxEnabled)
         |=> rxPushValid && !rxPush.parityErr;
   endproperty
   a_auto_keep_data: assert property (p_auto_keep_data)
      else $error("enabled receiver lost a data character");

   property p_md_enabled_data;
      (mdMode && rxCharValid && !rxChar.ninth && st_reg.rxEnabled)
         |=> rxPushValid && !rxPush.parityErr && (rxPush.data == $past(rxChar.data));
   endproperty
   a_md_enabled_data: assert property (p_md_enabled_data)
      else $error("enabled multidrop receiver lost data");

   property p_exact_compare;
      (autoMode && rxCharValid && rxChar.ninth && !st_reg.rxEnabled
         && rxChar.data != st_reg.matchChar) |=> !st_reg.rxEnabled || $past(ctrlWrite);
   endproperty
   a_exact_compare: assert property (p_exact_compare)
      else $error("near match enabled the receiver");

   property p_mode_select;
      (ctrlWrite && pwdata[CTRL_MULTIDROP_BIT] && !st_reg.scdEnable) |=> mdMode;
   endproperty
   a_mode_select: assert property (p_mode_select)
      else $error("multidrop bit did not select multidrop mode");

   property p_md_address_event;
      (mdMode && rxCharValid && rxChar.ninth) |=> st_reg.irqStatus[EV_ADDR_BIT];
   endproperty
   a_md_address_event: assert property (p_md_address_event)
      else $error("address character did not set its status bit");

   property p_md_drop_event;
      (mdMode && rxCharValid && !rxChar.ninth && !st_reg.rxEnabled)
         |=> st_reg.irqStatus[EV_DROP_BIT];
   endproperty
   a_md_drop_event: assert property (p_md_drop_event)
      else $error("dropped data character not reported");

   property p_md_line_irq;
      (mdMode && rxCharValid && rxChar.ninth && st_reg.irqEnable[EV_LINE_BIT]
         && !enWrite) |=> irq;
   endproperty
   a_md_line_irq: assert property (p_md_line_irq)
      else $error("no line status interrupt for address character");

   property p_md_enabled_address;
      (mdMode && rxCharValid && rxChar.ninth && st_reg.rxEnabled && !ctrlWrite)
         |=> rxPushValid && rxPush.parityErr && st_reg.rxEnabled;
   endproperty
   a_md_enabled_address: assert property (p_md_enabled_address)
      else $error("enabled receiver did not flag a new address");

   property p_auto_match_data;
      (autoMode && rxCharValid && rxChar.ninth && rxChar.data == st_reg.matchChar)
         |=> rxPush.data == $past(rxChar.data);
   endproperty
   a_auto_match_data: assert property (p_auto_match_data)
      else $error("matching address not pushed unchanged");

   property p_auto_match_keep;
      (autoMode && rxCharValid && rxChar.ninth && st_reg.rxEnabled
         && rxChar.data == st_reg.matchChar)
         |=> st_reg.rxEnabled && rxPushValid && rxPush.parityErr;
   endproperty
   a_auto_match_keep: assert property (p_auto_match_keep)
      else $error("matching address lost while receiver enabled");

   property p_rts_inverted_rx;
      (st_reg.ownsDir && st_reg.invert && !st_reg.dirActive) |=> !rtsN;
   endproperty
   a_rts_inverted_rx: assert property (p_rts_inverted_rx)
      else $error("inverted rts not low while receiving");

   property p_rts_manual_source;
      (!st_reg.ownsDir && !flowCtrlOn) |=> (rtsN == $past(manualRts));
   endproperty
   a_rts_manual_source: assert property (p_rts_manual_source)
      else $error("rts does not follow manual source");
endmodule // rmc_top

// file: test/rmc_far_station.sv
// far-side model: remote master station characters and transmit line timing
`timescale 1ns/1ps
module rmc_far_station
   import rmc_pkg::*;
#(
   parameter int FRAME_CYCLES = 12
)
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic txFifoWrite,
   output logic      txLastBitDone,
   output logic      rxCharValid,
   output rmc_char_t rxChar
);
   int txCount;

   initial begin
      txLastBitDone = 1'b0;
      rxCharValid   = 1'b0;
      rxChar        = '0;
      txCount       = 0;
   end

   // last stop bit leaves a fixed time after the fifo write
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txCount       <= 0;
         txLastBitDone <= 1'b0;
      end else begin
         txLastBitDone <= 1'b0;
         if (txFifoWrite === 1'b1) txCount <= FRAME_CYCLES;
         else if (txCount == 1) begin
            txLastBitDone <= 1'b1;
            txCount       <= 0;
         end else if (txCount > 1) txCount <= txCount - 1;
      end
   end

   // one character for one cycle; afterwards the line shows the inverse
   task automatic sendChar(input logic [7:0] d, input logic nine);
      @(posedge clk);
      rxCharValid <= 1'b1;
      rxChar      <= rmc_char_t'({d, nine, 1'b0});
      @(posedge clk);
      rxCharValid <= 1'b0;
      rxChar      <= rmc_char_t'(~{d, nine, 1'b0});
   endtask
endmodule // rmc_far_station

// file: test/testbench.sv
// self-checking bench for rs-485 direction control and multidrop gating
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
   import rmc_pkg::*;
;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        txFifoWrite, txLastBitDone, manualRts, flowCtrlOn, flowRts;
   logic        rxCharValid, rxPushValid, rtsN, irq;
   rmc_char_t   rxChar;
   rmc_push_t   rxPush;
   int          n_errors, num_checks;

   rmc_top rmc_top_inst (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txFifoWrite(txFifoWrite),
      .txLastBitDone(txLastBitDone), .manualRts(manualRts), .flowCtrlOn(flowCtrlOn),
      .flowRts(flowRts), .rxCharValid(rxCharValid), .rxChar(rxChar),
      .rxPushValid(rxPushValid), .rxPush(rxPush), .rtsN(rtsN), .irq(irq));
   rmc_far_station rmc_far_station_inst (.clk(clk), .arst_n(arst_n),
      .txFifoWrite(txFifoWrite), .txLastBitDone(txLastBitDone),
      .rxCharValid(rxCharValid), .rxChar(rxChar));

   // verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one apb transfer: setup, access until pready, then release
   task automatic apbXfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         n_errors++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic apbWrite(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apbXfer(a, 1'b1, d, rd, err);
      `CHK(err, 1'b0)
   endtask

   // masked register read against an expected value
   task automatic chkReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] rd;
      logic        err;
      apbXfer(a, 1'b0, 32'h0, rd, err);
      `CHK(err, 1'b0)
      `CHK(rd & m, e)
   endtask

   // one received character and the push it must or must not cause
   task automatic rxChk(input logic [7:0] d, input logic nine, input logic expPush);
      rmc_far_station_inst.sendChar(d, nine);
      #1;
      `CHK(rxPushValid, expPush)
      if (expPush) `CHK(rxPush, rmc_push_t'({d, nine}))
   endtask

   // one transmit frame: active level two edges after the write, idle after last bit
   task automatic txFrame(input logic actLvl);
      int i;
      @(posedge clk);
      txFifoWrite <= 1'b1;
      @(posedge clk);
      txFifoWrite <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(rtsN, actLvl)
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (txLastBitDone === 1'b1) break;
      end
      if (i == 100) begin
         n_errors++;
         end_sim();
      end
      @(posedge clk);
      #1;
      `CHK(rtsN, ~actLvl)
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   initial begin
      logic [31:0] rd;
      logic        err;
      {psel, penable, pwrite, paddr, pwdata, txFifoWrite} = '0;
      {manualRts, flowCtrlOn, flowRts} = 3'b101;
      arst_n = 1'b0;
      n_errors = 0;
      num_checks = 0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      `CHK(rtsN, 1'b1)
      `CHK(irq, 1'b0)
      chkReg(OFF_CTRL, ALL, 32'h0);
      chkReg(OFF_MATCH, ALL, 32'h0);
      chkReg(OFF_IEN, ALL, 32'h0);
      chkReg(OFF_RXSTAT, 32'h000f_0000, 32'h0001_0000);
      apbXfer(8'h1c, 1'b0, 32'h0, rd, err);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("test reset done");
      // direction pin sources and transmitter ownership
      @(posedge clk);
      flowCtrlOn <= 1'b1;
      flowRts    <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(rtsN, 1'b0)
      @(posedge clk);
      flowCtrlOn <= 1'b0;
      manualRts  <= 1'b0;
      apbWrite(OFF_CTRL, 32'h10);
      repeat (2) @(posedge clk);
      #1;
      `CHK(rtsN, 1'b1)
      txFrame(1'b0);
      apbWrite(OFF_CTRL, 32'h30);
      txFrame(1'b1);
      rxChk(8'h5a, 1'b0, 1'b1);
      $display("test direction done");
      // normal multidrop, receiver disabled, then enabled, then disabled again, detect off
      apbWrite(OFF_IEN, 32'h7);
      apbWrite(OFF_CTRL, 32'h3);
      rxChk(8'h33, 1'b0, 1'b0);
      chkReg(OFF_ISTAT, ALL, 32'h2);
      rxChk(8'h5a, 1'b1, 1'b1);
      apbWrite(OFF_ISTAT, 32'h0);
      chkReg(OFF_ISTAT, ALL, 32'h7);
      `CHK(irq, 1'b1)
      apbWrite(OFF_ICLR, 32'h7);
      chkReg(OFF_ICLR, ALL, 32'h0);
      `CHK(irq, 1'b0)
      apbWrite(OFF_CTRL, 32'h1);
      rxChk(8'h44, 1'b0, 1'b1);
      apbWrite(OFF_IEN, 32'h2);
      rxChk(8'h77, 1'b1, 1'b1);
      chkReg(OFF_ISTAT, ALL, 32'h5);
      `CHK(irq, 1'b0)
      apbWrite(OFF_CTRL, 32'h3);
      rxChk(8'h45, 1'b0, 1'b0);
      apbWrite(OFF_ICLR, 32'h7);
      $display("test multidrop done");
      // auto address detection against the stored match character
      apbWrite(OFF_FEAT, 32'h20);
      apbWrite(OFF_MATCH, 32'ha5);
      apbWrite(OFF_IEN, 32'h7);
      chkReg(OFF_MATCH, ALL, 32'ha5);
      chkReg(OFF_RXSTAT, 32'h0007_0000, 32'h0004_0000);
      rxChk(8'ha5, 1'b0, 1'b0);
      rxChk(8'ha4, 1'b1, 1'b0);
      rxChk(8'h25, 1'b1, 1'b0);
      rxChk(8'ha5, 1'b1, 1'b1);
      chkReg(OFF_RXSTAT, 32'h0007_0000, 32'h0005_0000);
      chkReg(OFF_ISTAT, 32'h4, 32'h4);
      `CHK(irq, 1'b1)
      rxChk(8'h11, 1'b0, 1'b1);
      rxChk(8'ha5, 1'b1, 1'b1);
      rxChk(8'h3c, 1'b1, 1'b0);
      chkReg(OFF_RXSTAT, 32'h0007_0000, 32'h0004_0000);
      rxChk(8'h12, 1'b0, 1'b0);
      $display("test auto address done");
      end_sim();
   end
endmodule // testbench
